// file: design/ddr2_power_state.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Exit timing starts at first high CKE edge.
// - Power-down entry needs CKE low with NOP.
// - Idle banks precharge power-down, else active.
// - Power-down disables buffers, freezes DLL in precharge.
// - Power-down exit on CKE high with NOP.
// - No refresh runs during power-down.
module ddr2_power_state #(
  parameter int NUM_BANKS = 8
) (
  input  wire logic                      mclk_in,
  input  wire logic                      reset_in,
  input  wire logic                      clk_en_in,
  input  wire ddr2_lp_pkg::pins_t        pins_in,
  input  wire logic                      slow_exit_in,
  output var  ddr2_lp_pkg::power_state_t power_state_out,
  output var  logic                      buffers_on_out,
  output var  logic                      dll_frozen_out,
  output var  logic                      self_refresh_out,
  output var  logic                      nonread_ok_out,
  output var  logic                      read_ok_out,
  output var  logic                      protocol_error_out
);

  import ddr2_lp_pkg::*;

  initial
  begin
    if (NUM_BANKS != (1 << BANK_W))
    begin
      $error("NUM_BANKS must match the bank address width.");
    end
    if (XSRD_CYCLES >= (1 << TIMER_W))
    begin
      $error("TIMER_W too small for the exit intervals.");
    end
  end

  localparam logic [TIMER_W-1:0] WRITE_BUSY =
    TIMER_W'(WRITE_END_CYCLES + wr_cycles(T_WR_NS, CLK_PERIOD_NS));

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  pins_t sync1_q;
  pins_t sync2_q;

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else if (clk_en_in)
    begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------
  // CKE history, bank and burst tracking
  // ----------------------------------------
  logic                 cke_prev_q;
  logic                 cke_prev_d;
  logic [1:0]           reg_cnt_q;
  logic [1:0]           reg_cnt_d;
  logic [NUM_BANKS-1:0] open_q;
  logic [NUM_BANKS-1:0] open_d;
  logic [TIMER_W-1:0]   busy_q;
  logic [TIMER_W-1:0]   busy_d;
  logic                 cke_rise;
  logic                 cke_fall;
  logic                 nop_now;
  cmd_t                 cmd;

  assign cmd      = sync2_q.cmd;
  assign nop_now  = is_nop(cmd);
  assign cke_rise = sync2_q.cke && !cke_prev_q;
  assign cke_fall = !sync2_q.cke && cke_prev_q;

  always_comb
  begin
    cke_prev_d = sync2_q.cke;
    reg_cnt_d  = reg_cnt_q;
    open_d     = open_q;
    busy_d     = (busy_q != '0) ? busy_q - 1'b1 : busy_q;
    if (cke_rise || cke_fall)
    begin
      reg_cnt_d = 2'h1;
    end
    else if (reg_cnt_q != 2'(CKE_MIN_REGS))
    begin
      reg_cnt_d = reg_cnt_q + 1'b1;
    end
    if (sync2_q.cke && cke_prev_q && !cmd.cs_n)
    begin
      if (is_cmd(cmd, CMD_ACTIVATE))
      begin
        open_d[cmd.bank] = 1'b1;
      end
      else if (is_cmd(cmd, CMD_PRECHARGE))
      begin
        if (cmd.a10)
        begin
          open_d = '0;
        end
        else
        begin
          open_d[cmd.bank] = 1'b0;
        end
      end
      else if (is_cmd(cmd, CMD_READ))
      begin
        busy_d = TIMER_W'(READ_END_CYCLES);
      end
      else if (is_cmd(cmd, CMD_WRITE))
      begin
        busy_d = WRITE_BUSY;
      end
      else if (is_cmd(cmd, CMD_LOAD_MODE))
      begin
        busy_d = TIMER_W'(MRD_CYCLES);
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      cke_prev_q <= 1'b0;
      reg_cnt_q  <= 2'(CKE_MIN_REGS);
      open_q     <= '0;
      busy_q     <= '0;
    end
    else if (clk_en_in)
    begin
      cke_prev_q <= cke_prev_d;
      reg_cnt_q  <= reg_cnt_d;
      open_q     <= open_d;
      busy_q     <= busy_d;
    end
  end

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  power_state_t       state_q;
  power_state_t       state_d;
  logic               buffers_q;
  logic               dll_frozen_q;
  logic               self_ref_q;
  logic               error_q;
  logic               error_d;
  logic               load_exit;
  logic [TIMER_W-1:0] nonread_val;
  logic [TIMER_W-1:0] read_val;

  // A transition with an illegal command leaves the state alone and is
  // only flagged; guessing an intent would corrupt the bank tracking.
  always_comb
  begin
    state_d     = state_q;
    error_d     = 1'b0;
    load_exit   = 1'b0;
    nonread_val = TIMER_W'(XP_CYCLES);
    read_val    = TIMER_W'(XP_CYCLES);
    if ((cke_rise || cke_fall) && (reg_cnt_q < 2'(CKE_MIN_REGS)))
    begin
      error_d = 1'b1;
    end
    case (state_q)
      PS_ACTIVE:
      begin
        if (cke_fall)
        begin
          if (busy_q != '0)
          begin
            error_d = 1'b1;
          end
          else if (nop_now)
          begin
            state_d = (open_q != '0) ? PS_ACTIVE_PD : PS_PRECHARGE_PD;
          end
          else if (is_cmd(cmd, CMD_REFRESH) && (open_q == '0))
          begin
            state_d = PS_SELF_REFRESH;
          end
          else
          begin
            error_d = 1'b1;
          end
        end
      end
      PS_PRECHARGE_PD, PS_ACTIVE_PD:
      begin
        if (cke_rise)
        begin
          if (nop_now)
          begin
            state_d   = PS_ACTIVE;
            load_exit = 1'b1;
            if (state_q == PS_ACTIVE_PD)
            begin
              read_val = slow_exit_in ? TIMER_W'(XARDS_CYCLES) : TIMER_W'(XARD_CYCLES);
            end
          end
          else
          begin
            error_d = 1'b1;
          end
        end
      end
      PS_SELF_REFRESH:
      begin
        if (cke_rise)
        begin
          if (nop_now)
          begin
            state_d     = PS_ACTIVE;
            load_exit   = 1'b1;
            nonread_val = TIMER_W'(XSNR_CYCLES);
            read_val    = TIMER_W'(XSRD_CYCLES);
          end
          else
          begin
            error_d = 1'b1;
          end
        end
      end
      default:
      begin
        state_d = PS_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      state_q      <= PS_ACTIVE;
      buffers_q    <= 1'b1;
      dll_frozen_q <= 1'b0;
      self_ref_q   <= 1'b0;
      error_q      <= 1'b0;
    end
    else if (clk_en_in)
    begin
      state_q      <= state_d;
      buffers_q    <= (state_d == PS_ACTIVE);
      dll_frozen_q <= (state_d == PS_PRECHARGE_PD);
      self_ref_q   <= (state_d == PS_SELF_REFRESH);
      error_q      <= error_d;
    end
  end

  // ----------------------------------------
  // Exit interval timers
  // ----------------------------------------
  interval_timer #(
    .W (TIMER_W)
  ) u_nonread_timer (
    .mclk_in   (mclk_in),
    .reset_in  (reset_in),
    .clk_en_in (clk_en_in),
    .load_in   (load_exit),
    .value_in  (nonread_val),
    .done_out  (nonread_ok_out)
  );

  interval_timer #(
    .W (TIMER_W)
  ) u_read_timer (
    .mclk_in   (mclk_in),
    .reset_in  (reset_in),
    .clk_en_in (clk_en_in),
    .load_in   (load_exit),
    .value_in  (read_val),
    .done_out  (read_ok_out)
  );

  assign power_state_out    = state_q;
  assign buffers_on_out     = buffers_q;
  assign dll_frozen_out     = dll_frozen_q;
  assign self_refresh_out   = self_ref_q;
  assign protocol_error_out = error_q;

endmodule

`default_nettype wire

// file: design/ddr2_lp_pkg.sv
package ddr2_lp_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int T_XSNR_NS       = 140;
  localparam int XSNR_CYCLES     = (T_XSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XSRD_CYCLES     = 200;
  localparam int CKE_MIN_REGS    = 3;
  localparam int XP_CYCLES       = 2;
  localparam int XARD_CYCLES     = 2;
  localparam int XARDS_CYCLES    = 6;
  localparam int T_WR_NS         = 15;
  localparam int WR_MIN_CYCLES   = 2;
  localparam int MRD_CYCLES      = 2;
  localparam int READ_END_CYCLES = 6;
  localparam int WRITE_END_CYCLES = 6;
  localparam int TIMER_W         = 8;
  localparam int BANK_W          = 3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PS_ACTIVE,
    PS_PRECHARGE_PD,
    PS_ACTIVE_PD,
    PS_SELF_REFRESH
  } power_state_t;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              a10;
    logic [BANK_W-1:0] bank;
  } cmd_t;

  typedef struct packed {
    logic cke;
    cmd_t cmd;
  } pins_t;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  function automatic logic [3:0] cmd_code(input cmd_t c);
    return {c.cs_n, c.ras_n, c.cas_n, c.we_n};
  endfunction

  function automatic logic is_nop(input cmd_t c);
    return c.cs_n || (cmd_code(c) == 4'h7);
  endfunction

  function automatic logic is_cmd(input cmd_t c, input logic [3:0] code);
    return (cmd_code(c) == code);
  endfunction

  localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
  localparam logic [3:0] CMD_REFRESH   = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
  localparam logic [3:0] CMD_WRITE     = 4'h4;
  localparam logic [3:0] CMD_READ      = 4'h5;

  // Write recovery in cycles: the larger of two and tWR over tCK, rounded up.
  function automatic int wr_cycles(input int twr_ns, input int tck_ns);
    int c;
    c = (twr_ns + tck_ns - 1) / tck_ns;
    return (c > WR_MIN_CYCLES) ? c : WR_MIN_CYCLES;
  endfunction

endpackage

// file: design/interval_timer.sv
`timescale 1ns/1ps
`default_nettype none

module interval_timer #(
  parameter int W = 8
) (
  input  wire logic         mclk_in,
  input  wire logic         reset_in,
  input  wire logic         clk_en_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] value_in,
  output var  logic         done_out
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic         done_q;
  logic         done_d;

  always_comb
  begin
    count_d = count_q;
    if (load_in)
    begin
      count_d = value_in;
    end
    else if (count_q != '0)
    begin
      count_d = count_q - 1'b1;
    end
    done_d = (count_d == '0);
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      count_q <= '0;
      done_q  <= 1'b1;
    end
    else if (clk_en_in)
    begin
      count_q <= count_d;
      done_q  <= done_d;
    end
  end

  assign done_out = done_q;

endmodule

`default_nettype wire

// file: verification/ddr2_power_state_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ddr2_power_state_chk #(
  parameter int NUM_BANKS = 8
) (
  input wire logic                      mclk_in,
  input wire logic                      reset_in,
  input wire ddr2_lp_pkg::pins_t        pins_in,
  input wire ddr2_lp_pkg::power_state_t power_state_out,
  input wire logic                      buffers_on_out,
  input wire logic                      dll_frozen_out,
  input wire logic                      self_refresh_out,
  input wire logic                      nonread_ok_out,
  input wire logic                      read_ok_out,
  input wire logic                      protocol_error_out
);
  import ddr2_lp_pkg::*;
  // ----------
  // Gap counters
  // ----------
  // Counting in logic keeps the long read gap out of repetition operators.
  logic [7:0] nr_low_q;
  logic [7:0] rd_low_q;
  always_ff @(posedge mclk_in)
  begin
    nr_low_q <= (reset_in || nonread_ok_out) ? 8'h00 : nr_low_q + 8'h01;
    rd_low_q <= (reset_in || read_ok_out) ? 8'h00 : rd_low_q + 8'h01;
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  a_buf_state: assert property (buffers_on_out == (power_state_out == PS_ACTIVE))
    else $error("buffer enable wrong");
  a_dll_freeze: assert property (dll_frozen_out == (power_state_out == PS_PRECHARGE_PD))
    else $error("dll freeze wrong");
  a_refresh_only: assert property (self_refresh_out == (power_state_out == PS_SELF_REFRESH))
    else $error("refresh flag wrong");
  a_state_cause: assert property ($changed(power_state_out) |-> $past(pins_in.cke, 3) != $past(pins_in.cke, 4))
    else $error("state moved without cke edge");
  a_pd_entry: assert property ($changed(power_state_out)
    && power_state_out inside {PS_PRECHARGE_PD, PS_ACTIVE_PD}
    |-> !$past(pins_in.cke, 3) && is_nop($past(pins_in.cmd, 3)))
    else $error("bad power-down entry");
  a_sr_entry: assert property ($changed(power_state_out) && power_state_out == PS_SELF_REFRESH
    |-> is_cmd($past(pins_in.cmd, 3), CMD_REFRESH) && $past(pins_in.cke, 4))
    else $error("bad self refresh entry");
  a_exit_nop: assert property (power_state_out != PS_ACTIVE && $past(pins_in.cke, 2)
    && !$past(pins_in.cke, 3) && is_nop($past(pins_in.cmd, 2)) |=> power_state_out == PS_ACTIVE)
    else $error("missed exit");
  a_bad_exit: assert property (power_state_out == PS_SELF_REFRESH && $past(pins_in.cke, 2)
    && !$past(pins_in.cke, 3) && !is_nop($past(pins_in.cmd, 2))
    |=> power_state_out == PS_SELF_REFRESH && protocol_error_out)
    else $error("illegal exit taken");
  a_nonread_gap: assert property ($rose(nonread_ok_out)
    |-> nr_low_q == XSNR_CYCLES || nr_low_q == XP_CYCLES)
    else $error("non-read gap wrong");
  a_read_gap: assert property ($rose(read_ok_out)
    |-> rd_low_q inside {XSRD_CYCLES, XARD_CYCLES, XARDS_CYCLES})
    else $error("read gap wrong");
  c_sr: cover property ($changed(power_state_out) && power_state_out == PS_SELF_REFRESH);
  c_apd: cover property ($changed(power_state_out) && power_state_out == PS_ACTIVE_PD);
  c_ppd: cover property ($changed(power_state_out) && power_state_out == PS_PRECHARGE_PD);
endmodule
bind ddr2_power_state ddr2_power_state_chk #(.NUM_BANKS(NUM_BANKS)) u_chk (
  .mclk_in(mclk_in), .reset_in(reset_in), .pins_in(pins_in),
  .power_state_out(power_state_out), .buffers_on_out(buffers_on_out),
  .dll_frozen_out(dll_frozen_out), .self_refresh_out(self_refresh_out),
  .nonread_ok_out(nonread_ok_out), .read_ok_out(read_ok_out),
  .protocol_error_out(protocol_error_out));
`default_nettype wire

// file: verification/ddr2_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ddr2_ctl_model (
  input  wire logic               mclk_in,
  output var  ddr2_lp_pkg::pins_t pins_out
);
  int seed = 65055;
  initial pins_out = 9'h080;
  // ----------
  // Command driver
  // ----------
  // Code F is a deselect; its ras_n, cas_n and we_n lines change every cycle on purpose.
  task automatic put(input logic c, input logic [3:0] k, input logic a10,
                     input logic [2:0] b, input int n);
    repeat (n)
    begin
      @(posedge mclk_in);
      pins_out <= {c, k[3] ? {1'b1, 3'($random(seed))} : k, a10, b};
    end
  endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ddr2_lp_pkg::*;
  typedef struct packed {logic c; logic [3:0] k; logic a10; logic [2:0] b; logic [7:0] n;
                         logic s;} op_t;
  typedef struct packed {power_state_t st; logic nr; logic rd; logic er;} exp_t;
  localparam int WR_REC = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_END = WRITE_END_CYCLES + (WR_REC > 2 ? WR_REC : 2);
  logic         mclk_in = 1'b0;
  logic         reset_in = 1'b1;
  logic         slow_exit_in = 1'b0;
  pins_t        pins;
  power_state_t state;
  logic         buf_on, dll_fz, sr_on, nr_ok, rd_ok, perr;
  int           miscompares = 0;
  int           compares = 0;
  int           banks, busy, run, nr_cnt, rd_cnt;
  power_state_t m_st;
  logic         pc;
  exp_t         e;
  exp_t         hist[$];
  // Reset rows carry a zero count; the rest keep every level for three edges, except the single CKE low cycle of row 17.
  op_t seq[22] = '{{1'b0,4'hF,1'b0,3'h0,8'd4,1'b0}, {1'b1,4'h7,1'b0,3'h0,8'd4,1'b0},
    {1'b1,4'h3,1'b0,3'h3,8'd1,1'b0}, {1'b1,4'h7,1'b0,3'h0,8'd3,1'b1},
    {1'b0,4'h7,1'b0,3'h0,8'd4,1'b1}, {1'b1,4'hF,1'b0,3'h0,8'd10,1'b1},
    {1'b1,4'h2,1'b1,3'h0,8'd1,1'b0}, {1'b1,4'h7,1'b0,3'h0,8'd3,1'b0},
    {1'b0,4'hF,1'b0,3'h0,8'd4,1'b0}, {1'b1,4'h7,1'b0,3'h0,8'd6,1'b0},
    {1'b0,4'h1,1'b0,3'h0,8'd1,1'b0}, {1'b0,4'hF,1'b0,3'h0,8'd5,1'b0},
    {1'b1,4'h7,1'b0,3'h0,8'd205,1'b0}, {1'b1,4'h5,1'b0,3'h0,8'd1,1'b0},
    {1'b0,4'h7,1'b0,3'h0,8'd4,1'b0}, {1'b1,4'h4,1'b0,3'h0,8'd1,1'b0},
    {1'b1,4'h7,1'b0,3'h0,8'd12,1'b0}, {1'b0,4'h7,1'b0,3'h0,8'd1,1'b0},
    {1'b1,4'h7,1'b0,3'h0,8'd4,1'b0}, {1'b0,4'h1,1'b0,3'h0,8'd4,1'b0},
    {1'b1,4'h3,1'b0,3'h1,8'd1,1'b0}, {1'b1,4'hF,1'b0,3'h0,8'd0,1'b0}};
  always #5 mclk_in = ~mclk_in;
  ddr2_ctl_model u_ddr2_ctl_model (.mclk_in(mclk_in), .pins_out(pins));
  ddr2_power_state u_ddr2_power_state (.mclk_in(mclk_in), .reset_in(reset_in),
    .clk_en_in(1'b1), .pins_in(pins), .slow_exit_in(slow_exit_in),
    .power_state_out(state), .buffers_on_out(buf_on), .dll_frozen_out(dll_fz),
    .self_refresh_out(sr_on), .nonread_ok_out(nr_ok), .read_ok_out(rd_ok),
    .protocol_error_out(perr));
  task automatic chk_state(input power_state_t got, input power_state_t exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: state %0d, expected %0d", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  // ----------
  // Reference model
  // ----------
  task automatic step(input pins_t p);
    logic [3:0] k;
    logic       nop;
    logic       er;
    int         bz;
    k = p.cmd[7:4];
    nop = p.cmd.cs_n || k == 4'h7;
    er = 1'b0;
    if (nr_cnt > 0) nr_cnt--;
    if (rd_cnt > 0) rd_cnt--;
    bz = busy;
    if (busy > 0) busy--;
    if (p.cke != pc)
    begin
      er = run < 3;
      run = 1;
    end
    else if (run < 9) run++;
    if (pc && p.cke)
    begin
      if (k == CMD_ACTIVATE) banks |= 1 << p.cmd.bank;
      if (k == CMD_PRECHARGE) banks = p.cmd.a10 ? 0 : banks & ~(1 << p.cmd.bank);
      if (k == CMD_READ) busy = READ_END_CYCLES;
      if (k == CMD_WRITE) busy = WR_END;
      if (k == CMD_LOAD_MODE) busy = MRD_CYCLES;
    end
    else if (pc && m_st == PS_ACTIVE)
    begin
      if (bz > 0) er = 1'b1;
      else if (nop) m_st = banks != 0 ? PS_ACTIVE_PD : PS_PRECHARGE_PD;
      else if (k == CMD_REFRESH && banks == 0) m_st = PS_SELF_REFRESH;
      else er = 1'b1;
    end
    else if (p.cke && !pc && m_st != PS_ACTIVE)
    begin
      if (!nop) er = 1'b1;
      else
      begin
        nr_cnt = m_st == PS_SELF_REFRESH ? XSNR_CYCLES : XP_CYCLES;
        rd_cnt = m_st == PS_SELF_REFRESH ? XSRD_CYCLES :
          (m_st == PS_ACTIVE_PD && slow_exit_in) ? XARDS_CYCLES : XARD_CYCLES;
        m_st = PS_ACTIVE;
      end
    end
    pc = p.cke;
    hist.push_back({m_st, nr_cnt == 0, rd_cnt == 0, er});
  endtask
  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      hist = {};
      m_st = PS_ACTIVE;
      {banks, busy, run, nr_cnt, rd_cnt, pc} = {32'd0, 32'd0, 32'd3, 32'd0, 32'd0, 1'b0};
    end
    else
    begin
      step(pins);
      if (hist.size() == 3)
      begin
        e = hist.pop_front();
        #1;
        chk_state(state, e.st);
        chk_bit(buf_on, e.st == PS_ACTIVE);
        chk_bit(dll_fz, e.st == PS_PRECHARGE_PD);
        chk_bit(sr_on, e.st == PS_SELF_REFRESH);
        chk_bit(nr_ok, e.nr);
        chk_bit(rd_ok, e.rd);
        chk_bit(perr, e.er);
      end
    end
  end
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------
  // Stimulus
  // ----------
  initial
  begin
    logic [31:0] r;
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    foreach (seq[i])
    begin
      slow_exit_in <= seq[i].s;
      if (seq[i].n == 8'h00)
      begin
        reset_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        reset_in <= 1'b0;
        u_ddr2_ctl_model.put(1'b0, 4'hF, 1'b0, 3'h0, 4);
      end
      else
        u_ddr2_ctl_model.put(seq[i].c, seq[i].k, seq[i].a10, seq[i].b, int'(seq[i].n));
    end
    for (int i = 0; i < 30; i++)
    begin
      r = $random(u_ddr2_ctl_model.seed);
      slow_exit_in <= r[4];
      u_ddr2_ctl_model.put(~i[0], r[3] ? 4'hF : 4'h7, r[5], r[8:6], 4 + int'(r[2:0]));
    end
    u_ddr2_ctl_model.put(1'b1, 4'h7, 1'b0, 3'h0, 8);
    give_verdict();
  end
  initial
  begin
    repeat (5000) @(posedge mclk_in);
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
